// ### rtl/dbgsel_defs.vh
// Constants for the debug path select block.
// Assumes inclusion by bare name from rtl/.
`ifndef DBGSEL_DEFS_VH
`define DBGSEL_DEFS_VH

// ----------------------------------------
// Path selection codes
// ----------------------------------------
`define DBGSEL_PATH_INSTR 1'b0
`define DBGSEL_PATH_TWIRE 1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define DBGSEL_CORE_PERIOD_NS 10
`define DBGSEL_LOW_HOLD_CYC 2

// ----------------------------------------
// TAP states, one-hot
// ----------------------------------------
`define DBGSEL_TAP_W 16
`define DBGSEL_TLR   16'h0001
`define DBGSEL_RTI   16'h0002
`define DBGSEL_SDRS  16'h0004
`define DBGSEL_CDR   16'h0008
`define DBGSEL_SDR   16'h0010
`define DBGSEL_E1DR  16'h0020
`define DBGSEL_PDR   16'h0040
`define DBGSEL_E2DR  16'h0080
`define DBGSEL_UDR   16'h0100
`define DBGSEL_SIRS  16'h0200
`define DBGSEL_CIR   16'h0400
`define DBGSEL_SIR   16'h0800
`define DBGSEL_E1IR  16'h1000
`define DBGSEL_PIR   16'h2000
`define DBGSEL_E2IR  16'h4000
`define DBGSEL_UIR   16'h8000

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define DBGSEL_IR_W      4
`define DBGSEL_IR_RESET  4'h1
`define DBGSEL_IR_BYPASS 4'hF
`define DBGSEL_IR_CAPT   4'h1

`endif

// ### rtl/dbgsel_top.v
// Debug path select with a minimal test access port.
// Assumes test pins arrive unsynchronised; pad logic resolves enables.
//
// How it works
// - Test clock high at reset end powers down the instrumentation block.
// - Instrumentation off: two-wire debug uses test clock and data-in pins.
// - Low on the TAP reset pin synchronously resets the TAP machine after a two-cycle synchroniser lag.
// - Instrumentation on: mode select is sampled on each rising test clock edge.
// - Instrumentation on: data-in pin is input only, sampled on rising edges.
// - Data-out pin changes only on falling test clock edges.
// - A valid trigger event gives an active-high pulse on the trigger pin.
// - Trigger pin driver is off when no pulse is driven.
// - Instrumentation off: data-in pin is the bidirectional two-wire data line.
// - After reset the shared data pin is an input, not driven.
// - Provide a standard TAP: clock, mode, data in, data out, TAP reset.
`timescale 1ns/10ps
`default_nettype none
`include "dbgsel_defs.vh"

module dbgsel_top
#(
  parameter LOW_HOLD_CYC = `DBGSEL_LOW_HOLD_CYC
)
(
  // Core clock and chip reset
  input  wire        core_clk,
  input  wire        rst,
  // Test access pins
  input  wire        tck_pin,
  input  wire        tms_pin,
  input  wire        tdi_in,
  output reg         tdi_out,
  output reg         tdi_oe,
  input  wire        trst_n_pin,
  output reg         tdo_out,
  output reg         tdo_oe,
  // Trigger pin, open drain style
  input  wire        trig_event,
  output reg         trigger_out_pin,
  output reg         trigger_oe,
  // Two-wire debug user side
  output reg         two_wire_clk_rise,
  output reg         two_wire_debug_data,
  input  wire        two_wire_drive,
  input  wire        two_wire_dout,
  // Selection state
  output reg         instr_enable,
  output reg         twire_enable
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg  [1:0] sync_tck;
  reg  [1:0] sync_tms;
  reg  [1:0] sync_tdi;
  reg  [1:0] sync_trst;
  reg        tck_d;
  wire       tck_s    = sync_tck[1];
  wire       tms_s    = sync_tms[1];
  wire       tdi_s    = sync_tdi[1];
  wire       trst_n_s = sync_trst[1];
  wire       tck_rise = tck_s & ~tck_d;
  wire       tck_fall = ~tck_s & tck_d;

  // Clock, mode and TAP reset pins reset to their pulled-up idle levels; data-in resets low
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_tck  <= 2'h3;
      sync_tms  <= 2'h3;
      sync_tdi  <= 2'h0;
      sync_trst <= 2'h3;
    end
    else
    begin
      sync_tck  <= {sync_tck[0], tck_pin};
      sync_tms  <= {sync_tms[0], tms_pin};
      sync_tdi  <= {sync_tdi[0], tdi_in};
      sync_trst <= {sync_trst[0], trst_n_pin};
    end
  end

  // ----------------------------------------
  // Test clock edge detect
  // ----------------------------------------
  // Starts high like the pulled-up pin, so an idle-high clock
  // gives no false rise after reset
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tck_d <= 1'b1;
    else
      tck_d <= tck_s;
  end

  // ----------------------------------------
  // Path selection
  // ----------------------------------------
  // The strap sampler has no reset, as it must watch the test clock
  // pin while chip reset is high. A shift history flushes any
  // power-up value within a few clocks.
  reg  [1:0]              strap_sync;
  reg  [LOW_HOLD_CYC-1:0] low_hist;
  wire [LOW_HOLD_CYC:0]   next_low_hist;
  wire                    strap_low_long;
  reg                     rst_d;

  // Top bit falls off on purpose: only the last samples count
  assign next_low_hist  = {low_hist, ~strap_sync[1]};
  assign strap_low_long = &low_hist;

  always @(posedge core_clk)
  begin
    strap_sync <= {strap_sync[0], tck_pin};
    low_hist   <= next_low_hist[LOW_HOLD_CYC-1:0];
    rst_d      <= rst;
  end

  // Decision taken once, on the first edge after chip reset falls
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      instr_enable <= 1'b0;
      twire_enable <= 1'b0;
    end
    else if (rst_d)
    begin
      if (strap_low_long)
      begin
        instr_enable <= 1'b1;
        twire_enable <= 1'b0;
      end
      else
      begin
        instr_enable <= 1'b0;
        twire_enable <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // TAP state machine
  // ----------------------------------------
  reg [`DBGSEL_TAP_W-1:0]  tap_state;
  reg [`DBGSEL_TAP_W-1:0]  next_tap_state;
  reg [`DBGSEL_IR_W-1:0]   ir_shift;
  reg [`DBGSEL_IR_W-1:0]   ir_hold;
  reg                      bypass_bit;
  wire                     tap_run = instr_enable & tck_rise;

  // One-hot state test, shared by the register and data-out paths
  function tap_is;
    input [`DBGSEL_TAP_W-1:0] state;
    input [`DBGSEL_TAP_W-1:0] code;
  begin
    tap_is = (state == code);
  end
  endfunction

  always @*
  begin
    case (tap_state)
      `DBGSEL_TLR:  next_tap_state = tms_s ? `DBGSEL_TLR  : `DBGSEL_RTI;
      `DBGSEL_RTI:  next_tap_state = tms_s ? `DBGSEL_SDRS : `DBGSEL_RTI;
      `DBGSEL_SDRS: next_tap_state = tms_s ? `DBGSEL_SIRS : `DBGSEL_CDR;
      `DBGSEL_CDR:  next_tap_state = tms_s ? `DBGSEL_E1DR : `DBGSEL_SDR;
      `DBGSEL_SDR:  next_tap_state = tms_s ? `DBGSEL_E1DR : `DBGSEL_SDR;
      `DBGSEL_E1DR: next_tap_state = tms_s ? `DBGSEL_UDR  : `DBGSEL_PDR;
      `DBGSEL_PDR:  next_tap_state = tms_s ? `DBGSEL_E2DR : `DBGSEL_PDR;
      `DBGSEL_E2DR: next_tap_state = tms_s ? `DBGSEL_UDR  : `DBGSEL_SDR;
      `DBGSEL_UDR:  next_tap_state = tms_s ? `DBGSEL_SDRS : `DBGSEL_RTI;
      `DBGSEL_SIRS: next_tap_state = tms_s ? `DBGSEL_TLR  : `DBGSEL_CIR;
      `DBGSEL_CIR:  next_tap_state = tms_s ? `DBGSEL_E1IR : `DBGSEL_SIR;
      `DBGSEL_SIR:  next_tap_state = tms_s ? `DBGSEL_E1IR : `DBGSEL_SIR;
      `DBGSEL_E1IR: next_tap_state = tms_s ? `DBGSEL_UIR  : `DBGSEL_PIR;
      `DBGSEL_PIR:  next_tap_state = tms_s ? `DBGSEL_E2IR : `DBGSEL_PIR;
      `DBGSEL_E2IR: next_tap_state = tms_s ? `DBGSEL_UIR  : `DBGSEL_SIR;
      `DBGSEL_UIR:  next_tap_state = tms_s ? `DBGSEL_SDRS : `DBGSEL_RTI;
      default:      next_tap_state = `DBGSEL_TLR;
    endcase
  end

  // Synchronised TAP reset keeps every flop in one domain; the pin is
  // asynchronous to this clock, so the two-cycle lag is accepted.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tap_state <= `DBGSEL_TLR;
    else if (!trst_n_s)
      tap_state <= `DBGSEL_TLR;
    else if (tap_run)
      tap_state <= next_tap_state;
  end

  // Instruction and bypass registers move on the same detected rise
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ir_shift   <= `DBGSEL_IR_RESET;
      ir_hold    <= `DBGSEL_IR_RESET;
      bypass_bit <= 1'b0;
    end
    else if (!trst_n_s)
    begin
      ir_shift   <= `DBGSEL_IR_RESET;
      ir_hold    <= `DBGSEL_IR_RESET;
      bypass_bit <= 1'b0;
    end
    else if (tap_run)
    begin
      if (tap_is(tap_state, `DBGSEL_TLR))
        ir_hold <= `DBGSEL_IR_RESET;
      else if (tap_is(tap_state, `DBGSEL_UIR))
        ir_hold <= ir_shift;
      if (tap_is(tap_state, `DBGSEL_CIR))
        ir_shift <= `DBGSEL_IR_CAPT;
      else if (tap_is(tap_state, `DBGSEL_SIR))
        ir_shift <= {tdi_s, ir_shift[`DBGSEL_IR_W-1:1]};
      if (tap_is(tap_state, `DBGSEL_CDR))
        bypass_bit <= 1'b0;
      else if (tap_is(tap_state, `DBGSEL_SDR))
        bypass_bit <= tdi_s;
    end
  end

  // ----------------------------------------
  // Data out, falling edge
  // ----------------------------------------
  // Enable follows the shift states only, so the pin floats between scans
  wire shifting_ir = tap_is(tap_state, `DBGSEL_SIR);
  wire shifting_dr = tap_is(tap_state, `DBGSEL_SDR);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end
    else if (instr_enable & tck_fall)
    begin
      tdo_out <= shifting_ir ? ir_shift[0] : bypass_bit;
      tdo_oe  <= shifting_ir | shifting_dr;
    end
    else if (!instr_enable)
      tdo_oe <= 1'b0;
  end

  // ----------------------------------------
  // Trigger pulse
  // ----------------------------------------
  // Registered so the open-drain pin never glitches on a decode race;
  // the pulse lags the event by one core cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      trigger_out_pin <= 1'b0;
      trigger_oe      <= 1'b0;
    end
    else
    begin
      trigger_out_pin <= instr_enable & trig_event;
      trigger_oe      <= instr_enable & trig_event;
    end
  end

  // ----------------------------------------
  // Two-wire data pin
  // ----------------------------------------
  // User side: one pulse per detected clock rise, data as sampled
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      two_wire_clk_rise   <= 1'b0;
      two_wire_debug_data <= 1'b0;
    end
    else
    begin
      two_wire_clk_rise   <= twire_enable & tck_rise;
      two_wire_debug_data <= tdi_s;
    end
  end

  // Pin side: the driver is gated by the path, so the line stays an
  // input in instrumentation mode whatever the user asks
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tdi_out <= 1'b0;
      tdi_oe  <= 1'b0;
    end
    else
    begin
      tdi_out <= two_wire_dout;
      tdi_oe  <= twire_enable & two_wire_drive;
    end
  end

endmodule
`default_nettype wire

// ### tb/dbgsel_assertions.sv
// Port checker for the debug path select block.
// Assumes a bind onto dbgsel_top; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module dbgsel_assertions (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck_pin,
  input wire logic trig_event,
  input wire logic trigger_out_pin,
  input wire logic trigger_oe,
  input wire logic tdi_oe,
  input wire logic tdi_out,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic two_wire_clk_rise,
  input wire logic two_wire_drive,
  input wire logic two_wire_dout,
  input wire logic instr_enable,
  input wire logic twire_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_tck_rise;
    $rose(tck_pin);
  endsequence
  sequence s_clk_pulse;
    ##[1:4] two_wire_clk_rise;
  endsequence
  AST_ONE_PATH: assert property (instr_enable |-> !twire_enable) else $error("both paths on");
  AST_HOLD: assert property ((instr_enable || twire_enable) |=> $stable({instr_enable, twire_enable}))
    else $error("path changed");
  AST_TRIG_PULSE: assert property (instr_enable && trig_event |=> trigger_out_pin) else $error("no trigger");
  AST_TRIG_CAUSE: assert property (trigger_out_pin |-> $past(trig_event) && instr_enable)
    else $error("stray trigger");
  AST_TRIG_OE: assert property (trigger_oe == trigger_out_pin) else $error("trigger driver on");
  AST_TDI_INPUT: assert property (instr_enable |-> !tdi_oe) else $error("data pin driven");
  AST_TDI_DRIVE: assert property (twire_enable && two_wire_drive |=>
    tdi_oe && tdi_out == $past(two_wire_dout)) else $error("data line not driven");
  AST_TWIRE_CLK: assert property (twire_enable ##0 s_tck_rise |-> s_clk_pulse) else $error("no clock pulse");
  AST_TDO_FALL: assert property ($changed(tdo_out) |-> !tck_pin && !$past(tck_pin, 2))
    else $error("data out moved off fall");
  AST_TAP_IDLE: assert property (twire_enable |-> !tdo_oe) else $error("tap active");
endmodule
bind dbgsel_top dbgsel_assertions chk (.*);
`default_nettype wire

// ### tb/dbgsel_probe.sv
// Debugger probe model driving the test pins.
// Assumes the bench calls its tasks from a core clock edge.
`timescale 1ns/10ps
`default_nettype none
module dbgsel_probe (
  // Pacing clock
  input  wire logic core_clk,
  // Pins toward the device
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Strap level; caller keeps it over reset release
  task automatic strap(input logic v);
    tck <= v;
  endtask
  // High phase of 8 core cycles, low phase of 9, well over twice the core period
  task automatic cyc(input logic m, input logic d);
  begin
    tms <= m;
    tdi <= d;
    hold(1);
    tck <= 1'b1;
    hold(8);
    tck <= 1'b0;
    hold(8);
  end
  endtask
  task automatic tap_reset;
  begin
    trst_n <= 1'b0;
    hold(6);
    trst_n <= 1'b1;
    hold(4);
  end
  endtask
endmodule
`default_nettype wire

// ### tb/test_dbgsel_top.sv
// Self-checking bench for the debug path select block.
// Assumes the probe model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_dbgsel_top;
  logic     core_clk;
  logic     rst;
  logic     trig_event;
  logic     two_wire_drive;
  logic     two_wire_dout;
  wire      tck_pin, tms_pin, probe_tdi, trst_n_pin, tdi_out, tdi_oe, tdo_out, tdo_oe;
  wire      trigger_out_pin, trigger_oe, two_wire_clk_rise, two_wire_debug_data, instr_enable, twire_enable;
  wire      tdi_line = tdi_oe ? tdi_out : probe_tdi;
  int       error_cnt = 0;
  int       comparisons = 0;
  int       rise_cnt = 0;
  dbgsel_probe probe (.core_clk(core_clk), .tck(tck_pin), .tms(tms_pin), .tdi(probe_tdi), .trst_n(trst_n_pin));
  dbgsel_top dut (.core_clk(core_clk), .rst(rst), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_in(tdi_line),
    .tdi_out(tdi_out), .tdi_oe(tdi_oe), .trst_n_pin(trst_n_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .trig_event(trig_event), .trigger_out_pin(trigger_out_pin), .trigger_oe(trigger_oe),
    .two_wire_clk_rise(two_wire_clk_rise), .two_wire_debug_data(two_wire_debug_data),
    .two_wire_drive(two_wire_drive), .two_wire_dout(two_wire_dout), .instr_enable(instr_enable),
    .twire_enable(twire_enable));
  // ----
  // Helpers
  // ----
  always @(posedge core_clk)
    if (two_wire_clk_rise === 1'b1)
      rise_cnt++;
  task automatic chk(input string name, input logic exp, input logic got);
  begin
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  end
  endtask
  task automatic report_and_stop;
  begin
    $display("Checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Mid-run reset with the strap set well before release
  task automatic do_reset(input logic strap_lvl);
  begin
    probe.strap(strap_lvl);
    rst <= 1'b1;
    probe.hold(6);
    rst <= 1'b0;
    probe.hold(2);
  end
  endtask
  task automatic to_shift_ir;
  begin
    probe.cyc(1'b0, 1'b0);
    probe.cyc(1'b1, 1'b0);
    probe.cyc(1'b1, 1'b0);
    probe.cyc(1'b0, 1'b0);
    probe.cyc(1'b0, 1'b0);
  end
  endtask
  task automatic trig_pulse(input logic exp);
  begin
    trig_event <= 1'b1;
    @(posedge core_clk);
    trig_event <= 1'b0;
    @(negedge core_clk);
    chk("trigger_out_pin", exp, trigger_out_pin);
    chk("trigger_oe", exp, trigger_oe);
    @(negedge core_clk);
    chk("trigger_out_pin", 1'b0, trigger_out_pin);
    chk("trigger_oe", 1'b0, trigger_oe);
    @(posedge core_clk);
  end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_instr;
  begin
    do_reset(1'b0);
    chk("instr_enable", 1'b1, instr_enable);
    chk("twire_enable", 1'b0, twire_enable);
    chk("tdi_oe", 1'b0, tdi_oe);
    trig_pulse(1'b1);
  end
  endtask
  task automatic t_jtag;
  begin
    to_shift_ir;
    chk("tdo_out", 1'b1, tdo_out);
    chk("tdo_oe", 1'b1, tdo_oe);
    probe.cyc(1'b0, 1'b0);
    chk("tdo_out", 1'b0, tdo_out);
    probe.cyc(1'b1, 1'b0);
    chk("tdo_oe", 1'b0, tdo_oe);
    probe.tap_reset;
    to_shift_ir;
    chk("tdo_oe", 1'b1, tdo_oe);
    repeat (4) probe.cyc(1'b0, 1'b1);
    chk("tdo_out", 1'b1, tdo_out);
    probe.cyc(1'b1, 1'b0);
  end
  endtask
  task automatic t_twire;
  begin
    do_reset(1'b1);
    chk("twire_enable", 1'b1, twire_enable);
    chk("instr_enable", 1'b0, instr_enable);
    chk("tdi_oe", 1'b0, tdi_oe);
    rise_cnt = 0;
    // Clock idles high after the strap, so only the second cycle rises
    repeat (2) probe.cyc(1'b1, 1'b1);
    chk("two_wire_clk_rise", 1'b1, rise_cnt == 1);
    chk("two_wire_debug_data", 1'b1, two_wire_debug_data);
    two_wire_drive <= 1'b1;
    probe.hold(5);
    chk("tdi_oe", 1'b1, tdi_oe);
    chk("two_wire_debug_data", 1'b0, two_wire_debug_data);
    two_wire_dout <= 1'b1;
    probe.hold(5);
    chk("tdi_out", 1'b1, tdi_out);
    chk("two_wire_debug_data", 1'b1, two_wire_debug_data);
    two_wire_drive <= 1'b0;
    two_wire_dout <= 1'b0;
    trig_pulse(1'b0);
  end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    rst = 1'b1;
    trig_event = 1'b0;
    two_wire_drive = 1'b0;
    two_wire_dout = 1'b0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_instr;
    t_jtag;
    t_twire;
    report_and_stop;
  end
endmodule
`default_nettype wire
